// ---- hdl/tmr8_pkg.sv ----
// Constants and types shared by the 8-bit timer/counter with one compare unit.
// Assumes an APB master with 32-bit data and byte addresses, one word per register.
package tmr8_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned PRESC_W = 10;

  // Register byte offsets.
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_COUNTER = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // Control register field positions.
  localparam int unsigned CTL_CS_LSB = 0;
  localparam int unsigned CTL_WAVE_LSB = 3;
  localparam int unsigned CTL_COM_LSB = 5;
  localparam int unsigned CTL_FORCE_BIT = 7;

  // Flag and mask register bit positions.
  localparam int unsigned BIT_OVF = 0;
  localparam int unsigned BIT_CMP = 1;

  // Waveform mode field encodings.
  localparam logic [1:0] WAVE_NORMAL = 2'h0;
  localparam logic [1:0] WAVE_PHASE_PWM = 2'h1;
  localparam logic [1:0] WAVE_CLEAR_ON_MATCH = 2'h2;
  localparam logic [1:0] WAVE_FAST_PWM = 2'h3;

  // Compare output mode field encodings.
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // Clock select field encodings.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Counter extremes.
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hff;

  // Reset values.
  localparam logic [7:0] RST_CNT = 8'h00;
  localparam logic [7:0] RST_CMP = 8'h00;
  localparam logic [9:0] RST_PRESC = 10'h000;

  typedef struct packed {
    logic [1:0] com;
    logic [1:0] wave;
    logic [2:0] cs;
  } tmr8_ctrl_s;

  localparam tmr8_ctrl_s RST_CTRL = 7'h00;

endpackage

// ---- hdl/tmr8_compare_counter.sv ----
// 8-bit timer/counter with one compare unit, reached over an APB slave.
// Assumes all inputs synchronous to I_MCLK; the interrupt controller pulses
// the acknowledge inputs when it runs the matching interrupt.
`timescale 1ns/10ps
module tmr8_compare_counter
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_EXTERNAL_COUNT_PIN,
  input wire logic I_GLOBAL_IRQ_ENABLE,
  input wire logic I_OVF_IRQ_ACK,
  input wire logic I_CMP_IRQ_ACK,
  output logic O_OVF_IRQ,
  output logic O_CMP_IRQ,
  output logic O_COMPARE_OUTPUT_PIN,
  output logic O_COMPARE_OUTPUT_EN
);

  tmr8_pkg::tmr8_ctrl_s ctrl;
  logic [7:0] counter_value;
  logic [7:0] compare_buf;
  logic [7:0] compare_value;
  logic [9:0] presc;
  logic ext_prev;
  logic count_down;
  logic match_block;
  logic overflow_flag;
  logic compare_flag;
  logic ovf_irq_enable;
  logic compare_irq_enable;
  logic compare_out;

  // Bus decode.
  wire setup_rd = I_PSEL && !I_PENABLE && !I_PWRITE;
  wire acc = I_PSEL && I_PENABLE;
  wire sel_ctl = I_PADDR == tmr8_pkg::OFF_CONTROL;
  wire sel_cnt = I_PADDR == tmr8_pkg::OFF_COUNTER;
  wire sel_cmp = I_PADDR == tmr8_pkg::OFF_COMPARE;
  wire sel_flg = I_PADDR == tmr8_pkg::OFF_FLAGS;
  wire sel_msk = I_PADDR == tmr8_pkg::OFF_MASK;
  wire mapped = sel_ctl || sel_cnt || sel_cmp || sel_flg || sel_msk;
  wire wr = acc && I_PWRITE && mapped;
  wire wr_ctl = wr && sel_ctl;
  wire wr_cnt = wr && sel_cnt;
  wire wr_cmp = wr && sel_cmp;
  wire wr_flg = wr && sel_flg;
  wire wr_msk = wr && sel_msk;

  // Mode decode.
  wire mode_pwm = ctrl.wave == tmr8_pkg::WAVE_PHASE_PWM || ctrl.wave == tmr8_pkg::WAVE_FAST_PWM;
  wire mode_phase = ctrl.wave == tmr8_pkg::WAVE_PHASE_PWM;
  wire mode_fast = ctrl.wave == tmr8_pkg::WAVE_FAST_PWM;
  wire mode_ctc = ctrl.wave == tmr8_pkg::WAVE_CLEAR_ON_MATCH;

  // Tick source selection; the prescaler taps fire when their low bits are all ones.
  wire ext_rise = I_EXTERNAL_COUNT_PIN && !ext_prev;
  wire ext_fall = !I_EXTERNAL_COUNT_PIN && ext_prev;
  logic timer_tick;
  always_comb
  begin
    unique case (ctrl.cs)
      tmr8_pkg::CS_STOP: timer_tick = 1'b0;
      tmr8_pkg::CS_DIV1: timer_tick = 1'b1;
      tmr8_pkg::CS_DIV8: timer_tick = &presc[2:0];
      tmr8_pkg::CS_DIV64: timer_tick = &presc[5:0];
      tmr8_pkg::CS_DIV256: timer_tick = &presc[7:0];
      tmr8_pkg::CS_DIV1024: timer_tick = &presc[9:0];
      tmr8_pkg::CS_EXT_FALL: timer_tick = ext_fall;
      tmr8_pkg::CS_EXT_RISE: timer_tick = ext_rise;
    endcase
  end

  // Extremes and comparator.
  wire at_bottom = counter_value == tmr8_pkg::CNT_BOTTOM;
  wire at_max = counter_value == tmr8_pkg::CNT_MAX;
  wire at_top = mode_ctc ? (counter_value == compare_value) : at_max;
  wire match = counter_value == compare_value;
  wire match_hit = timer_tick && match && !match_block;

  // Counter sequence per waveform mode.
  logic [7:0] next_counter_value;
  logic next_count_down;
  logic ovf_event;
  always_comb
  begin
    next_counter_value = counter_value;
    next_count_down = count_down;
    ovf_event = 1'b0;
    if (timer_tick)
    begin
      unique case (ctrl.wave)
        tmr8_pkg::WAVE_NORMAL, tmr8_pkg::WAVE_FAST_PWM:
        begin
          next_counter_value = counter_value + 8'h01;
          ovf_event = at_max;
        end
        tmr8_pkg::WAVE_CLEAR_ON_MATCH:
        begin
          if (match_hit)
          begin
            next_counter_value = tmr8_pkg::CNT_BOTTOM;
          end
          else
          begin
            next_counter_value = counter_value + 8'h01;
            ovf_event = at_max;
          end
        end
        tmr8_pkg::WAVE_PHASE_PWM:
        begin
          if (!count_down && at_max)
          begin
            next_count_down = 1'b1;
            next_counter_value = counter_value - 8'h01;
          end
          else if (count_down && at_bottom)
          begin
            next_count_down = 1'b0;
            next_counter_value = counter_value + 8'h01;
            ovf_event = 1'b1;
          end
          else if (count_down)
          begin
            next_counter_value = counter_value - 8'h01;
          end
          else
          begin
            next_counter_value = counter_value + 8'h01;
          end
        end
      endcase
    end
    if (wr_cnt)
    begin
      next_counter_value = I_PWDATA[7:0];
    end
  end

  // Force strobe acts only in non-PWM modes.
  wire force_hit = wr_ctl && I_PWDATA[tmr8_pkg::CTL_FORCE_BIT] && !mode_pwm;
  wire [1:0] wr_com = I_PWDATA[tmr8_pkg::CTL_COM_LSB +: 2];

  // Waveform generator for the internal compare output state.
  logic next_compare_out;
  always_comb
  begin
    next_compare_out = compare_out;
    if (!mode_pwm && (match_hit || force_hit))
    begin
      unique case (force_hit ? wr_com : ctrl.com)
        tmr8_pkg::COM_OFF: next_compare_out = compare_out;
        tmr8_pkg::COM_TOGGLE: next_compare_out = !compare_out;
        tmr8_pkg::COM_CLEAR: next_compare_out = 1'b0;
        tmr8_pkg::COM_SET: next_compare_out = 1'b1;
      endcase
    end
    else if (mode_fast && (ctrl.com == tmr8_pkg::COM_CLEAR || ctrl.com == tmr8_pkg::COM_SET))
    begin
      if (match_hit)
      begin
        next_compare_out = ctrl.com == tmr8_pkg::COM_SET;
      end
      else if (timer_tick && at_max)
      begin
        next_compare_out = ctrl.com == tmr8_pkg::COM_CLEAR;
      end
    end
    else if (mode_phase && match_hit)
    begin
      if (ctrl.com == tmr8_pkg::COM_CLEAR)
      begin
        next_compare_out = count_down;
      end
      else if (ctrl.com == tmr8_pkg::COM_SET)
      begin
        next_compare_out = !count_down;
      end
    end
  end

  // Compare value: direct in non-PWM modes, loaded at top (count 0xff) in both PWM modes.
  wire cmp_load_pwm = timer_tick && ((mode_fast && at_max) || (mode_phase && at_top));
  logic [7:0] next_compare_value;
  always_comb
  begin
    if (!mode_pwm && wr_cmp)
    begin
      next_compare_value = I_PWDATA[7:0];
    end
    else if (cmp_load_pwm)
    begin
      next_compare_value = compare_buf;
    end
    else
    begin
      next_compare_value = compare_value;
    end
  end

  // Flags: a set in the same cycle as a clear wins.
  wire ovf_clr = (wr_flg && I_PWDATA[tmr8_pkg::BIT_OVF]) || I_OVF_IRQ_ACK;
  wire cmp_clr = (wr_flg && I_PWDATA[tmr8_pkg::BIT_CMP]) || I_CMP_IRQ_ACK;
  wire next_overflow_flag = ovf_event || (overflow_flag && !ovf_clr);
  wire next_compare_flag = match_hit || (compare_flag && !cmp_clr);

  // A counter write blocks the next tick's match; the block ends on a tick without a counter write.
  wire next_match_block = wr_cnt || (match_block && !timer_tick);

  // Read data is captured in the setup cycle and held through the access phase.
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (sel_ctl)
    begin
      rd_mux[6:0] = ctrl;
    end
    else if (sel_cnt)
    begin
      rd_mux[7:0] = counter_value;
    end
    else if (sel_cmp)
    begin
      rd_mux[7:0] = compare_buf;
    end
    else if (sel_flg)
    begin
      rd_mux[tmr8_pkg::BIT_OVF] = overflow_flag;
      rd_mux[tmr8_pkg::BIT_CMP] = compare_flag;
    end
    else if (sel_msk)
    begin
      rd_mux[tmr8_pkg::BIT_OVF] = ovf_irq_enable;
      rd_mux[tmr8_pkg::BIT_CMP] = compare_irq_enable;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      O_PRDATA <= 32'h0000_0000;
    end
    else if (setup_rd)
    begin
      O_PRDATA <= rd_mux;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      ctrl <= tmr8_pkg::RST_CTRL;
      ovf_irq_enable <= 1'b0;
      compare_irq_enable <= 1'b0;
      compare_buf <= tmr8_pkg::RST_CMP;
    end
    else
    begin
      if (wr_ctl)
      begin
        ctrl <= I_PWDATA[6:0];
      end
      if (wr_msk)
      begin
        ovf_irq_enable <= I_PWDATA[tmr8_pkg::BIT_OVF];
        compare_irq_enable <= I_PWDATA[tmr8_pkg::BIT_CMP];
      end
      if (wr_cmp)
      begin
        compare_buf <= I_PWDATA[7:0];
      end
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      counter_value <= tmr8_pkg::RST_CNT;
      compare_value <= tmr8_pkg::RST_CMP;
      count_down <= 1'b0;
    end
    else
    begin
      counter_value <= next_counter_value;
      compare_value <= next_compare_value;
      count_down <= next_count_down;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      match_block <= 1'b0;
      compare_out <= 1'b0;
    end
    else
    begin
      match_block <= next_match_block;
      compare_out <= next_compare_out;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
    end
    else
    begin
      overflow_flag <= next_overflow_flag;
      compare_flag <= next_compare_flag;
    end
  end

  // The prescaler is cleared only by reset, so the first divided tick after a start may come early.
  always_ff @(posedge I_MCLK)
  begin
    if (I_RST)
    begin
      presc <= tmr8_pkg::RST_PRESC;
      ext_prev <= 1'b0;
    end
    else
    begin
      presc <= presc + 10'h001;
      ext_prev <= I_EXTERNAL_COUNT_PIN;
    end
  end

  assign O_PREADY = 1'b1;
  assign O_PSLVERR = acc && !mapped;
  assign O_OVF_IRQ = overflow_flag && ovf_irq_enable && I_GLOBAL_IRQ_ENABLE;
  assign O_CMP_IRQ = compare_flag && compare_irq_enable && I_GLOBAL_IRQ_ENABLE;
  assign O_COMPARE_OUTPUT_PIN = compare_out;
  assign O_COMPARE_OUTPUT_EN = ctrl.com != tmr8_pkg::COM_OFF;

endmodule

// ---- verification/tmr8_chk.sv ----
// Assertions on the ports of the 8-bit timer/counter.
// Assumes binding into tmr8_compare_counter; one clock, synchronous reset.
`timescale 1ns/10ps
module tmr8_chk
(
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic I_GLOBAL_IRQ_ENABLE,
  input wire logic I_OVF_IRQ_ACK,
  input wire logic I_CMP_IRQ_ACK,
  input wire logic O_OVF_IRQ,
  input wire logic O_CMP_IRQ,
  input wire logic O_COMPARE_OUTPUT_PIN,
  input wire logic O_COMPARE_OUTPUT_EN
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RST);
  wire acc = I_PSEL & I_PENABLE;
  wire wr_any = acc & I_PWRITE;
  wire wr_ctl = wr_any & (I_PADDR == tmr8_pkg::OFF_CONTROL);
  wire mapped = (I_PADDR[1:0] == 2'h0) & (I_PADDR <= tmr8_pkg::OFF_MASK);
  property p_ready; acc |-> O_PREADY; endproperty
  a_ready: assert property (p_ready) else $error("access not ready");
  property p_slverr; acc |-> (O_PSLVERR == !mapped); endproperty
  a_slverr: assert property (p_slverr) else $error("slave error wrong");
  property p_reset; disable iff (1'b0)
    I_RST |=> !O_CMP_IRQ && !O_OVF_IRQ && !O_COMPARE_OUTPUT_PIN && !O_COMPARE_OUTPUT_EN;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_en_wr; wr_ctl |=> O_COMPARE_OUTPUT_EN == ($past(I_PWDATA[6:5]) != 2'h0); endproperty
  a_en_wr: assert property (p_en_wr) else $error("pin enable wrong after write");
  property p_en_hold; !wr_ctl |=> $stable(O_COMPARE_OUTPUT_EN); endproperty
  a_en_hold: assert property (p_en_hold) else $error("pin enable moved");
  property p_cmp_gie; O_CMP_IRQ |-> I_GLOBAL_IRQ_ENABLE; endproperty
  a_cmp_gie: assert property (p_cmp_gie) else $error("compare irq without enable");
  property p_ovf_gie; O_OVF_IRQ |-> I_GLOBAL_IRQ_ENABLE; endproperty
  a_ovf_gie: assert property (p_ovf_gie) else $error("overflow irq without enable");
  property p_cmp_fall;
    $fell(O_CMP_IRQ) |-> $past(I_CMP_IRQ_ACK) || $past(wr_any) || $past(I_RST)
      || !I_GLOBAL_IRQ_ENABLE;
  endproperty
  a_cmp_fall: assert property (p_cmp_fall) else $error("compare irq dropped alone");
  property p_ovf_fall;
    $fell(O_OVF_IRQ) |-> $past(I_OVF_IRQ_ACK) || $past(wr_any) || $past(I_RST)
      || !I_GLOBAL_IRQ_ENABLE;
  endproperty
  a_ovf_fall: assert property (p_ovf_fall) else $error("overflow irq dropped alone");
  c_cmp: cover property ($rose(O_CMP_IRQ));
  c_ovf: cover property ($rose(O_OVF_IRQ));
  c_err: cover property (acc && O_PSLVERR);
  c_pin: cover property ($changed(O_COMPARE_OUTPUT_PIN));
endmodule

bind tmr8_compare_counter tmr8_chk u_chk (.*);

// ---- verification/test_tmr8_compare_counter.sv ----
// Self-checking testbench for the 8-bit timer/counter with one compare unit.
// Assumes the design package and the bound checker are compiled first.
`timescale 1ns/10ps
module test_tmr8_compare_counter;
  localparam logic [7:0] CTL = tmr8_pkg::OFF_CONTROL;
  localparam logic [7:0] CNT = tmr8_pkg::OFF_COUNTER;
  localparam logic [7:0] CMP = tmr8_pkg::OFF_COMPARE;
  localparam logic [7:0] FLG = tmr8_pkg::OFF_FLAGS;
  localparam logic [7:0] MSK = tmr8_pkg::OFF_MASK;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic ext = 1'b0;
  logic gie = 1'b0;
  logic oack = 1'b0;
  logic cack = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, ovf_irq, cmp_irq, pin, pin_en, err;
  int errors = 0;
  int checks = 0;

  tmr8_compare_counter uut
  (
    .I_MCLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_EXTERNAL_COUNT_PIN(ext), .I_GLOBAL_IRQ_ENABLE(gie),
    .I_OVF_IRQ_ACK(oack), .I_CMP_IRQ_ACK(cack), .O_OVF_IRQ(ovf_irq), .O_CMP_IRQ(cmp_irq),
    .O_COMPARE_OUTPUT_PIN(pin), .O_COMPARE_OUTPUT_EN(pin_en)
  );

  initial
    forever #4 clk = ~clk;

  function automatic logic [31:0] ctl(input logic [1:0] c, input logic [1:0] w,
                                      input logic [2:0] s);
    return {25'h0, c, w, s};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
    chk(err, a > MSK);
  endtask

  // Edge pulse on an acknowledge input.
  task automatic pulse(input logic o);
    oack <= o;
    cack <= !o;
    @(posedge clk);
    oack <= 1'b0;
    cack <= 1'b0;
    @(negedge clk);
  endtask

  task automatic t_reset;
    for (int a = 0; a <= 20; a += 4)
      rdc(8'(a), 32'h0);
    chk({pin, pin_en, ovf_irq, cmp_irq}, 4'h0);
  endtask

  task automatic t_regs;
    wr(CNT, 32'h1a5);
    wr(CMP, 32'h5a);
    wr(8'h14, 32'hff);
    repeat (5) @(posedge clk);
    rdc(CNT, 32'ha5);
    rdc(CMP, 32'h5a);
    rdc(CTL, 32'h0);
  endtask

  task automatic t_ovf;
    wr(MSK, 32'h3);
    gie <= 1'b1;
    wr(CNT, 32'hfc);
    wr(CTL, ctl(2'h0, 2'h0, 3'h1));
    repeat (8) @(posedge clk);
    wr(CTL, 32'h0);
    rdc(CNT, 32'h07);
    rdc(FLG, 32'h1);
    chk(ovf_irq, 1'b1);
    wr(FLG, 32'h2);
    rdc(FLG, 32'h1);
    pulse(1'b1);
    chk(ovf_irq, 1'b0);
  endtask

  task automatic t_cmp;
    wr(CNT, 32'h5);
    wr(CMP, 32'h5);
    wr(CTL, ctl(2'h0, 2'h0, 3'h1));
    repeat (4) @(posedge clk);
    wr(CTL, 32'h0);
    rdc(FLG, 32'h0);
    wr(CNT, 32'h9);
    wr(CMP, 32'ha);
    wr(CTL, ctl(2'h0, 2'h0, 3'h1));
    repeat (4) @(posedge clk);
    wr(CTL, 32'h0);
    rdc(FLG, 32'h2);
    chk(cmp_irq, 1'b1);
    wr(MSK, 32'h1);
    @(negedge clk);
    chk(cmp_irq, 1'b0);
    wr(MSK, 32'h3);
    gie <= 1'b0;
    @(negedge clk);
    chk(cmp_irq, 1'b0);
    @(posedge clk);
    gie <= 1'b1;
    @(negedge clk);
    chk(cmp_irq, 1'b1);
    wr(FLG, 32'h0);
    rdc(FLG, 32'h2);
    pulse(1'b0);
    rdc(FLG, 32'h0);
  endtask

  task automatic t_ctc;
    wr(CNT, 32'h0);
    wr(CTL, ctl(2'h0, 2'h2, 3'h1));
    repeat (40) @(posedge clk);
    wr(CTL, 32'h0);
    rdc(CNT, 32'ha);
    rdc(FLG, 32'h2);
    wr(FLG, 32'h3);
  endtask

  task automatic t_force;
    logic [1:0] cm [4] = '{2'h1, 2'h1, 2'h3, 2'h2};
    for (int i = 0; i < 4; i++)
    begin
      wr(CTL, 32'h80 | ctl(cm[i], 2'h0, 3'h0));
      @(negedge clk);
      chk(pin, (i % 2) == 0);
      chk(pin_en, 1'b1);
    end
    rdc(CTL, ctl(2'h2, 2'h0, 3'h0));
    rdc(CNT, 32'ha);
    rdc(FLG, 32'h0);
  endtask

  task automatic t_pwm;
    wr(CTL, ctl(2'h0, 2'h3, 3'h0));
    wr(CMP, 32'h20);
    wr(CNT, 32'h1e);
    wr(CTL, ctl(2'h0, 2'h3, 3'h1));
    repeat (4) @(posedge clk);
    wr(CTL, ctl(2'h0, 2'h3, 3'h0));
    rdc(FLG, 32'h0);
    rdc(CMP, 32'h20);
    wr(CMP, 32'h02);
    wr(CNT, 32'hfd);
    wr(CTL, ctl(2'h3, 2'h3, 3'h1));
    repeat (5) @(posedge clk);
    wr(CTL, 32'h0);
    rdc(FLG, 32'h3);
    rdc(CNT, 32'h05);
    chk(pin, 1'b1);
    wr(FLG, 32'h3);
  endtask

  task automatic t_phase;
    wr(CMP, 32'h02);
    wr(CNT, 32'h00);
    wr(CTL, ctl(2'h2, 2'h1, 3'h1));
    repeat (20) @(posedge clk);
    wr(CTL, ctl(2'h2, 2'h1, 3'h0));
    chk(pin, 1'b0);
    rdc(CNT, 32'h17);
    rdc(FLG, 32'h2);
    wr(FLG, 32'h3);
    wr(CTL, ctl(2'h2, 2'h1, 3'h1));
    repeat (485) @(posedge clk);
    wr(CTL, 32'h0);
    chk(pin, 1'b1);
    rdc(CNT, 32'h01);
    rdc(FLG, 32'h3);
    wr(FLG, 32'h3);
  endtask

  task automatic t_ext;
    wr(CNT, 32'h0);
    for (int s = 6; s <= 7; s++)
    begin
      wr(CTL, ctl(2'h0, 2'h0, 3'(s)));
      repeat (6) @(posedge clk) ext <= !ext;
      repeat (3) @(posedge clk);
      wr(CTL, 32'h0);
      rdc(CNT, 32'(3 * (s - 5)));
    end
  endtask

  task automatic t_presc;
    int dv [4] = '{8, 64, 256, 1024};
    for (int s = 2; s <= 5; s++)
    begin
      wr(CNT, 32'h0);
      wr(CTL, ctl(2'h0, 2'h0, 3'(s)));
      repeat (1021) @(posedge clk);
      wr(CTL, 32'h0);
      rdc(CNT, 32'(1024 / dv[s - 2]));
    end
  endtask

  task automatic finish_test;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #100us;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_regs;
    t_ovf;
    t_cmp;
    t_ctc;
    t_force;
    t_pwm;
    t_phase;
    t_ext;
    t_presc;
    finish_test;
  end
endmodule
